// ==== rtl/dcvls_pkg.sv ====
// package for the dual chamber vacuum load sequencer
// assumes a 40 MHz core clock and an Avalon-MM register master
package dcvls_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;

    // ****************************************
    // register map (byte addresses, 32-bit words)
    // ****************************************
    localparam logic [3:0] REG_CTRL_A = 4'h0;
    localparam logic [3:0] REG_CTRL_B = 4'h4;
    localparam logic [3:0] REG_SYS = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // ctrl word field positions
    localparam int FLD_LOAD_LSB = 0;
    localparam int FLD_DUMP_LSB = 8;
    localparam int FLD_MODE_LSB = 16;
    localparam int FLD_AIR_BIT = 18;
    // sys word bits
    localparam int SYS_RUN_BIT = 0;
    localparam int SYS_DUAL_BIT = 1;
    localparam int SYS_TWOHTR_BIT = 2;
    localparam int SYS_FACTORY_BIT = 3;

    // ****************************************
    // types and factory values
    // ****************************************
    typedef enum logic [1:0] {
        DCVLS_MODE_OFF = 2'h0,
        DCVLS_MODE_ON = 2'h1,
        DCVLS_MODE_RUN_WHILE_DRYER_OFF = 2'h2
    } dcvls_mode_t;

    typedef struct packed {
        logic conveying_air_source;
        dcvls_mode_t mode;
        logic [7:0] discharge_duration;
        logic [7:0] fill_duration;
    } dcvls_chamber_cfg_t;

    localparam logic AIR_DRY = 1'b1;
    localparam logic AIR_AMBIENT = 1'b0;
    localparam logic [7:0] DUR_MIN = 8'h01;
    localparam dcvls_chamber_cfg_t CFG_A_RESET = '{AIR_DRY, DCVLS_MODE_ON, 8'h0A, 8'h08};
    localparam dcvls_chamber_cfg_t CFG_B_RESET = '{AIR_AMBIENT, DCVLS_MODE_ON, 8'h0A, 8'h0A};

    localparam logic [7:0] CH_M = 8'h4D;
    localparam logic [7:0] CH_DASH = 8'h2D;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_B = 8'h42;
    localparam logic [7:0] CH_W = 8'h57;
    localparam logic [7:0] CH_D = 8'h44;
    localparam logic [39:0] MSG_NOT_AVAIL = 40'h4E2F412020;

endpackage : dcvls_pkg

// ==== rtl/dcvls_chamber.sv ====
// one chamber's load/dump timer
// assumes a one-second tick pulse and a grant from the arbiter
`timescale 1ns/1ps
module dcvls_chamber
    import dcvls_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic allowed,
    input wire logic material_absent,
    input wire logic grant,
    input wire logic [7:0] fill_duration,
    input wire logic [7:0] discharge_duration,
    output logic request,
    output logic loading,
    output logic dumping
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_DUMP} dcvls_ch_state_t;
    dcvls_ch_state_t state_ff;
    logic [7:0] cnt_ff;

    assign request = (state_ff == ST_IDLE) && allowed && material_absent; // R20 R24
    assign loading = (state_ff == ST_LOAD);
    assign dumping = (state_ff == ST_DUMP);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (request && grant) begin
                        state_ff <= ST_LOAD; // R20
                        cnt_ff <= fill_duration;
                    end
                end
                ST_LOAD: begin
                    if (tick) begin
                        if (cnt_ff <= 8'h01) begin
                            state_ff <= ST_DUMP; // R21
                            cnt_ff <= discharge_duration;
                        end else begin
                            cnt_ff <= cnt_ff - 8'h01;
                        end
                    end
                end
                ST_DUMP: begin
                    if (tick) begin
                        if (cnt_ff <= 8'h01) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            cnt_ff <= cnt_ff - 8'h01;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    a_load_needs_grant: assert property (@(posedge core_clk) disable iff (srst)
        $rose(loading) |-> $past(grant)) else $error("load started without grant"); // R23
endmodule : dcvls_chamber

// ==== rtl/dcvls_top.sv ====
// dual chamber vacuum load sequencer top: registers, arbiter, relays, status view
// assumes synchronous level inputs and an Avalon-MM master on core_clk
//
// Summary of operation
// R1: each chamber mode is off, on, or run while dryer off
// R2: factory reset sets both chamber modes to on
// R3: fill duration 1..255 seconds; zero writes are refused
// R4: factory fill duration of chamber A is 8 seconds
// R5: discharge duration 1..255 seconds, separate from fill duration
// R6: factory A discharge and B fill and discharge are 10 seconds
// R7: exhaust diverter follows the loading chamber's air source setting
// R8: factory air source: A dry, B ambient
// R9: single-chamber systems ignore chamber B settings
// R10: status char one: M or dash for chamber A level
// R11: status char two: M or dash for chamber B level
// R12: status char three: S stopped or R running blower
// R13: status char four: A or B diverter position
// R14: status char five: W ambient or D dry exhaust
// R15: two-heater unit shows not available message instead
// R16: de-energized level input means material present
// R17: blower output energized runs the blower
// R18: chamber select low points at A, high at B
// R19: exhaust diverter low ambient, high dry
// R20: enabled chamber lacking material loads for its fill duration
// R21: after fill, chamber dumps for its discharge duration
// R22: one chamber may dump while the other loads
// R23: only one chamber loads at a time; alternate when both ask
// R24: one-second tick times durations; disabled chambers never load
`timescale 1ns/1ps
module dcvls_top
    import dcvls_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic level_a_in,
    input wire logic level_b_in,
    output logic vacuum_blower_output,
    output logic chamber_select_output,
    output logic exhaust_diverter_output,
    output logic [39:0] conveying_status_view
);

    // ****************************************
    // registers
    // ****************************************
    dcvls_chamber_cfg_t cfg_ff [2];
    logic dryer_running_ff;
    logic dual_ff;
    logic two_heater_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;

    function automatic dcvls_chamber_cfg_t merge_cfg(input dcvls_chamber_cfg_t old,
                                                     input logic [31:0] wd,
                                                     input logic [3:0] be);
        dcvls_chamber_cfg_t r;
        r = old;
        if (be[0] && wd[7:0] >= DUR_MIN) r.fill_duration = wd[7:0]; // R3
        if (be[1] && wd[15:8] >= DUR_MIN) r.discharge_duration = wd[15:8]; // R5
        if (be[2] && wd[17:16] != 2'h3) r.mode = dcvls_mode_t'(wd[17:16]); // R1
        if (be[2]) r.conveying_air_source = wd[FLD_AIR_BIT];
        return r;
    endfunction : merge_cfg

    logic bus_req;
    logic bus_wr;
    assign bus_req = (avs_read || avs_write) && !ack_ff;
    // writes land on the edge that samples waitrequest low
    assign bus_wr = avs_write && ack_ff;
    // one wait cycle per access keeps reads registered
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata = rdata_ff;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    logic factory_wr;
    assign factory_wr = bus_wr && avs_address == REG_SYS && avs_byteenable[0]
                        && avs_writedata[SYS_FACTORY_BIT];

    always_ff @(posedge core_clk) begin
        if (srst || factory_wr) begin
            cfg_ff[0] <= CFG_A_RESET; // R2 R4 R6 R8
            cfg_ff[1] <= CFG_B_RESET; // R2 R6 R8
        end else if (bus_wr && avs_address == REG_CTRL_A) begin
            cfg_ff[0] <= merge_cfg(cfg_ff[0], avs_writedata, avs_byteenable);
        end else if (bus_wr && avs_address == REG_CTRL_B) begin
            cfg_ff[1] <= merge_cfg(cfg_ff[1], avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dryer_running_ff <= 1'b1;
            dual_ff <= 1'b1;
            two_heater_ff <= 1'b0;
        end else if (bus_wr && avs_address == REG_SYS && avs_byteenable[0]) begin
            dryer_running_ff <= avs_writedata[SYS_RUN_BIT];
            dual_ff <= avs_writedata[SYS_DUAL_BIT];
            two_heater_ff <= avs_writedata[SYS_TWOHTR_BIT];
        end
    end

    // ****************************************
    // one-second tick
    // ****************************************
    logic [31:0] div_ff;
    logic tick;
    assign tick = (div_ff == TICK_DIV - 1); // R24
    always_ff @(posedge core_clk) begin
        if (srst || tick) begin
            div_ff <= 32'h0;
        end else begin
            div_ff <= div_ff + 32'h1;
        end
    end

    // ****************************************
    // chambers and arbiter
    // ****************************************
    logic [1:0] absent;
    logic [1:0] allowed;
    logic [1:0] req;
    logic [1:0] grant;
    logic [1:0] loading;
    logic [1:0] dumping;
    logic last_b_ff;

    assign absent = {level_b_in, level_a_in}; // R16

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            // chamber B is inert on a single-chamber system
            assign allowed[gi] = (gi == 0 || dual_ff) // R9
                && (cfg_ff[gi].mode == DCVLS_MODE_RUN_WHILE_DRYER_OFF
                    || (cfg_ff[gi].mode == DCVLS_MODE_ON && dryer_running_ff)); // R24
            dcvls_chamber u_ch (
                .core_clk(core_clk),
                .srst(srst),
                .tick(tick),
                .allowed(allowed[gi]),
                .material_absent(absent[gi]),
                .grant(grant[gi]),
                .fill_duration(cfg_ff[gi].fill_duration),
                .discharge_duration(cfg_ff[gi].discharge_duration),
                .request(req[gi]),
                .loading(loading[gi]),
                .dumping(dumping[gi])
            );
        end
    endgenerate

    // the other chamber may be dumping; only loading blocks a grant
    always_comb begin
        grant = 2'b00;
        if (loading == 2'b00) begin // R22 R23
            if (req == 2'b11) begin
                grant = last_b_ff ? 2'b01 : 2'b10; // R23
            end else begin
                grant = req;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            last_b_ff <= 1'b0;
        end else if (grant != 2'b00) begin
            last_b_ff <= grant[1];
        end
    end

    // ****************************************
    // relay outputs
    // ****************************************
    logic sel_b_ff;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sel_b_ff <= 1'b0;
        end else if (loading != 2'b00) begin
            sel_b_ff <= loading[1];
        end
    end

    // diverter holds position after a load to save relay wear
    assign vacuum_blower_output = |loading; // R17 R20
    assign chamber_select_output = sel_b_ff; // R18
    assign exhaust_diverter_output = cfg_ff[sel_b_ff].conveying_air_source; // R7 R19

    // ****************************************
    // status view and read data
    // ****************************************
    logic [39:0] nxt_view;
    always_comb begin
        nxt_view[39:32] = absent[0] ? CH_DASH : CH_M; // R10
        nxt_view[31:24] = absent[1] ? CH_DASH : CH_M; // R11
        nxt_view[23:16] = vacuum_blower_output ? CH_R : CH_S; // R12
        nxt_view[15:8] = chamber_select_output ? CH_B : CH_A; // R13
        nxt_view[7:0] = exhaust_diverter_output ? CH_D : CH_W; // R14
        if (two_heater_ff) nxt_view = MSG_NOT_AVAIL; // R15
    end

    logic [39:0] view_ff;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            view_ff <= MSG_NOT_AVAIL;
        end else begin
            view_ff <= nxt_view;
        end
    end
    assign conveying_status_view = view_ff;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_ff <= 32'h0;
        end else if (avs_read && !ack_ff) begin
            case (avs_address)
                REG_CTRL_A: rdata_ff <= {13'h0, cfg_ff[0]};
                REG_CTRL_B: rdata_ff <= {13'h0, cfg_ff[1]};
                REG_SYS: rdata_ff <= {29'h0, two_heater_ff, dual_ff, dryer_running_ff};
                REG_STATUS: rdata_ff <= {23'h0, dumping, loading, exhaust_diverter_output,
                                         chamber_select_output, vacuum_blower_output,
                                         absent[1], absent[0]};
                default: rdata_ff <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_one_loader: assert property (@(posedge core_clk) disable iff (srst)
        loading != 2'b11) else $error("both chambers loading"); // R23
    a_blower_loading: assert property (@(posedge core_clk) disable iff (srst)
        vacuum_blower_output == (loading != 2'b00)) else $error("blower mismatch"); // R17
    a_b_single_idle: assert property (@(posedge core_clk) disable iff (srst)
        !dual_ff |-> !req[1]) else $error("chamber B active on single system"); // R9
    a_no_load_off: assert property (@(posedge core_clk) disable iff (srst)
        cfg_ff[0].mode == DCVLS_MODE_OFF |-> !req[0]) else $error("disabled A asks"); // R24
    a_fill_nonzero: assert property (@(posedge core_clk) disable iff (srst)
        cfg_ff[0].fill_duration != 8'h00 && cfg_ff[1].fill_duration != 8'h00)
        else $error("zero fill duration"); // R3
    a_dump_nonzero: assert property (@(posedge core_clk) disable iff (srst)
        cfg_ff[0].discharge_duration != 8'h00) else $error("zero dump duration"); // R5
    a_load_to_dump: assert property (@(posedge core_clk) disable iff (srst)
        $fell(loading[0]) |-> dumping[0]) else $error("load not followed by dump"); // R21
    a_view_blower: assert property (@(posedge core_clk) disable iff (srst)
        !two_heater_ff && !$past(two_heater_ff) |=> view_ff[23:16] ==
        ($past(vacuum_blower_output) ? CH_R : CH_S)) else $error("view blower"); // R12
    a_select_follows: assert property (@(posedge core_clk) disable iff (srst)
        loading[1] |=> chamber_select_output) else $error("select not B"); // R18

    c_load_a: cover property (@(posedge core_clk) disable iff (srst) $rose(loading[0]));
    c_load_b: cover property (@(posedge core_clk) disable iff (srst) $rose(loading[1]));
    c_overlap: cover property (@(posedge core_clk) disable iff (srst)
        loading[0] && dumping[1]);
    c_both_ask: cover property (@(posedge core_clk) disable iff (srst) req == 2'b11);

endmodule : dcvls_top

// ==== verif/dcvls_plant.sv ====
// plant model: two chamber level switches fed by the vacuum blower and chamber select relays
// assumes relay outputs from the sequencer and drain pulses from the bench
`timescale 1ns/1ps
module dcvls_plant
    import dcvls_pkg::*;
#(
    parameter int unsigned FILL_CYC = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic vacuum_blower_output,
    input wire logic chamber_select_output,
    input wire logic drain_a,
    input wire logic drain_b,
    output logic level_a_in,
    output logic level_b_in
);
    // ****************************************
    // material in each chamber
    // ****************************************
    logic [1:0] full_ff;
    logic [7:0] run_ff;
    logic sel_ff;

    // conveying counts only while the blower pulls on one chamber without a switch-over
    always_ff @(posedge core_clk) begin
        if (srst) begin
            run_ff <= 8'h00;
            sel_ff <= 1'b0;
        end else begin
            sel_ff <= chamber_select_output;
            if (!vacuum_blower_output || sel_ff != chamber_select_output) begin
                run_ff <= 8'h00;
            end else if (run_ff < 8'hFF) begin
                run_ff <= run_ff + 8'h01;
            end
        end
    end

    // material arrives well before the shortest load ends, so a fill never repeats
    always_ff @(posedge core_clk) begin
        if (srst) begin
            full_ff <= 2'h3;
        end else begin
            if (drain_a) full_ff[0] <= 1'b0;
            if (drain_b) full_ff[1] <= 1'b0;
            if (run_ff == 8'(FILL_CYC)) full_ff[chamber_select_output] <= 1'b1;
        end
    end

    assign level_a_in = ~full_ff[0];
    assign level_b_in = ~full_ff[1];
endmodule : dcvls_plant

// ==== verif/dcvls_top_tb.sv ====
// bench for the dual chamber vacuum load sequencer
// assumes the plant model on the level inputs and a short tick divider
`timescale 1ns/1ps
module dcvls_top_tb
    import dcvls_pkg::*;
;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam int unsigned TDIV = 10;
    logic core_clk, srst, avs_read, avs_write, drain_a, drain_b, level_a_in, level_b_in;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rnd;
    logic avs_waitrequest, vacuum_blower_output, chamber_select_output, exhaust_diverter_output;
    logic [39:0] conveying_status_view;
    logic [31:0] exp_q[$];
    int err_total, check_count, cyc;

    dcvls_top #(.TICK_DIV(TDIV)) u_dut (.core_clk(core_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .level_a_in(level_a_in), .level_b_in(level_b_in),
        .vacuum_blower_output(vacuum_blower_output),
        .chamber_select_output(chamber_select_output),
        .exhaust_diverter_output(exhaust_diverter_output),
        .conveying_status_view(conveying_status_view));
    dcvls_plant #(.FILL_CYC(8)) u_plant (.core_clk(core_clk), .srst(srst),
        .vacuum_blower_output(vacuum_blower_output),
        .chamber_select_output(chamber_select_output), .drain_a(drain_a), .drain_b(drain_b),
        .level_a_in(level_a_in), .level_b_in(level_b_in));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic conclude();
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp, input string what);
        chk({39'h0, got}, {39'h0, exp}, what);
    endtask : chk1

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [31:0] cfg(input logic air, input logic [1:0] md,
                                        input logic [7:0] dmp, input logic [7:0] fil);
        return {13'h0, air, md, dmp, fil};
    endfunction : cfg

    // one edge passes first, so a release and the next request never share a time step
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk1(n == 2, 1'b1, "one wait state");
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic drain(input logic a, input logic b);
        drain_a <= a;
        drain_b <= b;
        @(posedge core_clk);
        drain_a <= 1'b0;
        drain_b <= 1'b0;
    endtask : drain

    task automatic wait_blow(input logic v, input int mx, output int n);
        n = 0;
        while (vacuum_blower_output !== v && n < mx) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_blow

    // read results come off the queue at the edge that ends the access
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk({8'h00, avs_readdata}, {8'h00, exp_q.pop_front()}, "read data");
        end
    end

    initial begin
        cyc = 0;
        forever begin
            @(posedge core_clk);
            cyc++;
            if (cyc == 20000) begin
                err_total++;
                $display("[ERR] %0t run timed out", $time);
                conclude();
            end
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        int n;
        logic [7:0] f, d;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {drain_a, drain_b, err_total, check_count} = '0;
        rnd = 32'h00FF2CAC;
        f = 8'h0A;
        d = 8'h0A;
        srst = 1'b1;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(conveying_status_view, {CH_M, CH_M, CH_S, CH_A, CH_D}, "idle view");
        rd(REG_CTRL_A, {13'h0, CFG_A_RESET});
        rd(REG_CTRL_B, {13'h0, CFG_B_RESET});
        rd(REG_SYS, 32'h3);
        rd(REG_STATUS, 32'h00000010);
        rd(4'h2, 32'h0);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr_next(rnd);
            f = rnd[7:0] | 8'h01;
            d = rnd[15:8] | 8'h01;
            bus(1'b1, REG_CTRL_B, cfg(1'b0, 2'h1, d, f));
            rd(REG_CTRL_B, cfg(1'b0, 2'h1, d, f));
        end
        bus(1'b1, REG_CTRL_B, cfg(1'b0, 2'h1, 8'h00, 8'h00));
        rd(REG_CTRL_B, cfg(1'b0, 2'h1, d, f));
        bus(1'b1, REG_CTRL_B, cfg(1'b0, 2'h3, d, f));
        rd(REG_CTRL_B, cfg(1'b0, 2'h1, d, f));
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, REG_CTRL_B, cfg(1'b0, 2'(m), d, f));
            rd(REG_CTRL_B, cfg(1'b0, 2'(m), d, f));
        end
        bus(1'b1, REG_SYS, 32'h0000000B);
        rd(REG_CTRL_B, {13'h0, CFG_B_RESET});
        rd(REG_SYS, 32'h3);
        bus(1'b1, REG_CTRL_A, cfg(1'b1, 2'h1, 8'h02, 8'h03));
        bus(1'b1, REG_CTRL_B, cfg(1'b0, 2'h1, 8'h02, 8'h03));
        drain(1'b1, 1'b0);
        wait_blow(1'b1, 4, n);
        chk1(vacuum_blower_output, 1'b1, "load start");
        repeat (2) @(posedge core_clk);
        chk(conveying_status_view, {CH_DASH, CH_M, CH_R, CH_A, CH_D}, "load view");
        chk1(chamber_select_output, 1'b0, "select a");
        chk1(exhaust_diverter_output, 1'b1, "dry exhaust");
        wait_blow(1'b0, 200, n);
        chk1(n + 2 > 2 * TDIV && n + 2 <= 3 * TDIV, 1'b1, "load length");
        repeat (40) @(posedge core_clk);
        drain(1'b1, 1'b1);
        wait_blow(1'b1, 4, n);
        repeat (2) @(posedge core_clk);
        chk1(chamber_select_output, 1'b1, "b first");
        chk1(exhaust_diverter_output, 1'b0, "ambient exhaust");
        n = 0;
        while (chamber_select_output !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        chk1(vacuum_blower_output, 1'b1, "a loads while b dumps");
        chk1(exhaust_diverter_output, 1'b1, "a dry exhaust");
        repeat (80) @(posedge core_clk);
        bus(1'b1, REG_CTRL_A, cfg(1'b1, 2'h0, 8'h02, 8'h03));
        drain(1'b1, 1'b0);
        wait_blow(1'b1, 40, n);
        chk(40'(n), 40'd40, "disabled stays idle");
        bus(1'b1, REG_CTRL_A, cfg(1'b1, 2'h1, 8'h02, 8'h03));
        wait_blow(1'b1, 6, n);
        chk1(n < 6, 1'b1, "enabled loads");
        repeat (80) @(posedge core_clk);
        bus(1'b1, REG_SYS, 32'h2);
        drain(1'b1, 1'b0);
        wait_blow(1'b1, 40, n);
        chk(40'(n), 40'd40, "dryer off idle");
        bus(1'b1, REG_CTRL_A, cfg(1'b1, 2'h2, 8'h02, 8'h03));
        wait_blow(1'b1, 6, n);
        chk1(n < 6, 1'b1, "runs while dryer off");
        repeat (80) @(posedge core_clk);
        bus(1'b1, REG_SYS, 32'h1);
        bus(1'b1, REG_CTRL_A, cfg(1'b0, 2'h1, 8'h02, 8'h03));
        bus(1'b1, REG_CTRL_B, cfg(1'b1, 2'h1, 8'h01, 8'h01));
        drain(1'b1, 1'b1);
        wait_blow(1'b1, 6, n);
        repeat (2) @(posedge core_clk);
        chk1(chamber_select_output, 1'b0, "single select");
        chk1(exhaust_diverter_output, 1'b0, "single exhaust");
        wait_blow(1'b0, 200, n);
        chk1(n + 2 > 2 * TDIV && n + 2 <= 3 * TDIV, 1'b1, "single length");
        wait_blow(1'b1, 60, n);
        chk(40'(n), 40'd60, "b ignored");
        bus(1'b1, REG_SYS, 32'h7);
        repeat (2) @(posedge core_clk);
        chk(conveying_status_view, MSG_NOT_AVAIL, "two heater view");
        conclude();
    end
endmodule : dcvls_top_tb
